// File: wseq_top.sv
// Waveform segment sequencer: allocator, segment list and sample player
// ==========================================================================
// Overview of operation
// - Each region is contiguous, sized up to whole 128-byte blocks
// - Regions are placed back to back in write order
// - Session start frees the whole memory
// - Three modes, of which script mode has no player here; host selects one before starting
// - Sequence mode keeps samples and instructions in shared memory
// - Sequence mode plays segments strictly in listed order
// - Short sample count plays only the first samples
// - Sample count above stored length is reported and not generated
// - Sample count zero means the full stored length
// - Each segment repeats its span loop-count times, up to 16,777,215
// - Marker pulses at its offset from waveform start, zero is first
// - Samples are signed 16-bit words passed at full width
// - Odd waveform lengths are refused
// ==========================================================================
//
// The implementer's own choices: the register addresses and the plain strobed port.
module wseq_top
    import wseq_pkg::*;
(
    input wire logic i_core_clk,
    input wire logic i_reset,
    input wire logic [ADDR_W-1:0] i_addr,
    input wire logic [31:0] i_wdata,
    input wire logic i_wr,
    input wire logic i_rd,
    output logic [31:0] o_rdata,
    output logic signed [SAMPLE_W-1:0] o_sample,
    output logic o_sample_valid,
    output logic o_marker,
    output logic o_busy,
    output logic o_irq
);
    // ======================================================================
    // Storage
    // ======================================================================
    logic [SAMPLE_W-1:0] mem_reg [MEM_WORDS];
    logic [MEM_AW:0] free_reg;                // Next free word, block aligned
    logic [MEM_AW-1:0] wr_ptr_reg;
    logic [MEM_AW-1:0] wfm_base_reg [NUM_WFM];
    logic [MEM_AW:0] wfm_len_reg [NUM_WFM];
    logic [WFM_IW-1:0] wfm_cnt_reg;
    logic [WFM_IW-1:0] seg_wfm_reg;
    logic [SEG_IW-1:0] seg_idx_reg;
    logic [MEM_AW:0] seg_cnt_reg;
    logic [LOOP_W-1:0] seg_loop_reg;
    logic [MEM_AW-1:0] seq_base_reg;          // Instruction region start
    logic [SEG_IW:0] seq_len_reg;
    logic [1:0] mode_reg;
    logic [ST_W-1:0] status_reg;
    logic [ST_W-1:0] mask_reg;
    state_t state_reg;
    logic [SEG_IW:0] cur_seg_reg;
    logic [MEM_AW:0] pos_reg;
    logic [LOOP_W-1:0] loop_reg;
    logic [MEM_AW-1:0] p_base_reg;
    logic [MEM_AW:0] p_span_reg;
    logic [MEM_AW:0] p_mark_reg;
    logic [LOOP_W-1:0] p_loops_reg;

    logic wr_hit;
    logic [MEM_AW:0] alloc_words;
    logic [MEM_AW+1:0] alloc_end;
    logic ev_done, ev_seg_err, ev_len_err, ev_full_err;
    logic go;
    logic len_big;
    logic [MEM_AW-1:0] ins_addr;
    logic [WFM_IW-1:0] f_wfm;
    logic [MEM_AW:0] f_cnt, f_len, f_span;

    assign wr_hit = i_wr;
    assign go = i_wr && i_addr == A_CTRL && i_wdata[2];
    // Script mode has no player in this block, so its go is dropped below
    // Lengths past the memory would wrap the rounding adder; refuse them
    assign len_big = i_wdata > 32'(MEM_WORDS);

    // Round up to whole blocks
    assign alloc_words = MEM_AW'(0) + (((i_wdata[MEM_AW:0] +
        (MEM_AW+1)'(BLOCK_WORDS - 1)) >> BLK_SHIFT) << BLK_SHIFT);
    assign alloc_end = {1'b0, free_reg} + {1'b0, alloc_words};

    // ======================================================================
    // Allocator and sample loading
    // ======================================================================
    // Regions appended at the free pointer in write order
    always_ff @(posedge i_core_clk) begin
        ev_len_err <= 1'b0;
        ev_full_err <= 1'b0;
        if (i_reset) begin
            free_reg <= '0;
            wr_ptr_reg <= '0;
            wfm_cnt_reg <= '0;
            seq_base_reg <= '0;
        end else if (wr_hit && i_addr == A_RESET_MEM) begin
            free_reg <= '0;
            wfm_cnt_reg <= '0;
        end else if (wr_hit && i_addr == A_WFM_LEN) begin
            if (i_wdata[0] || i_wdata[MEM_AW:0] == '0) begin
                ev_len_err <= 1'b1;
            end else if (len_big ||
                alloc_end > (MEM_AW+2)'(MEM_WORDS)) begin
                ev_full_err <= 1'b1;
            end else begin
                wfm_base_reg[wfm_cnt_reg] <= free_reg[MEM_AW-1:0];
                wfm_len_reg[wfm_cnt_reg] <= i_wdata[MEM_AW:0];
                wr_ptr_reg <= free_reg[MEM_AW-1:0];
                free_reg <= alloc_end[MEM_AW:0];
                wfm_cnt_reg <= wfm_cnt_reg + 1'b1;
            end
        end else if (wr_hit && i_addr == A_SEQ_LEN) begin
            // Instruction region also takes whole blocks
            if ({1'b0, free_reg} + (MEM_AW+2)'(BLOCK_WORDS) >
                (MEM_AW+2)'(MEM_WORDS)) begin
                ev_full_err <= 1'b1;             // No room for the list
            end else begin
                seq_base_reg <= free_reg[MEM_AW-1:0];
                free_reg <= free_reg + (MEM_AW+1)'(BLOCK_WORDS);
            end
        end else if (wr_hit && i_addr == A_WFM_DATA) begin
            wr_ptr_reg <= wr_ptr_reg + 1'b1;
        end
    end

    // Samples and instruction words share one memory
    assign ins_addr = seq_base_reg + MEM_AW'({seg_idx_reg, 2'b00});
    always_ff @(posedge i_core_clk) begin
        if (wr_hit && i_addr == A_WFM_DATA) begin
            mem_reg[wr_ptr_reg] <= i_wdata[SAMPLE_W-1:0];
        end else if (wr_hit && i_addr == A_SEG_MARK) begin
            // High loop bits ride above the handle in word zero
            mem_reg[ins_addr] <= {seg_loop_reg[LOOP_W-1:16], 5'h00,
                seg_wfm_reg};
            mem_reg[ins_addr + 1'b1] <= 16'(seg_cnt_reg);
            mem_reg[ins_addr + 2'h2] <= seg_loop_reg[15:0];
            mem_reg[ins_addr + 2'h3] <= 16'(i_wdata[MEM_AW:0]);
        end
    end

    // Segment staging registers
    always_ff @(posedge i_core_clk) begin
        if (i_reset) begin
            seg_wfm_reg <= '0;
            seg_idx_reg <= '0;
            seg_cnt_reg <= '0;
            seg_loop_reg <= '0;
            seq_len_reg <= '0;
            mode_reg <= MODE_WFM;
        end else if (wr_hit) begin
            case (i_addr)
                A_SEG_CFG: begin
                    seg_idx_reg <= i_wdata[3:0];
                    seg_wfm_reg <= i_wdata[6:4];
                end
                A_SEG_CNT: seg_cnt_reg <= i_wdata[MEM_AW:0];
                A_SEG_LOOP: seg_loop_reg <= i_wdata[LOOP_W-1:0];
                A_SEQ_LEN: begin
                    // A list longer than the table is cut to the table
                    seq_len_reg <= i_wdata > 32'(NUM_SEG) ?
                        (SEG_IW+1)'(NUM_SEG) : i_wdata[SEG_IW:0];
                end
                A_CTRL: if (state_reg == S_IDLE) begin
                    mode_reg <= i_wdata[1:0];
                end
                default: ;
            endcase
        end
    end

    // ======================================================================
    // Player
    // ======================================================================
    // Fetch fields of the current segment from its instruction words
    assign f_wfm = mode_reg == MODE_WFM ? '0 :
        mem_reg[seq_base_reg + MEM_AW'({cur_seg_reg[SEG_IW-1:0], 2'b00})]
        [WFM_IW-1:0];
    assign f_cnt = mode_reg == MODE_WFM ? '0 :
        (MEM_AW+1)'(mem_reg[seq_base_reg +
        MEM_AW'({cur_seg_reg[SEG_IW-1:0], 2'b01})]);
    assign f_len = wfm_len_reg[f_wfm];
    assign f_span = f_cnt == '0 ? f_len : f_cnt;

    always_ff @(posedge i_core_clk) begin
        ev_done <= 1'b0;
        ev_seg_err <= 1'b0;
        o_sample_valid <= 1'b0;
        o_marker <= 1'b0;
        if (i_reset) begin
            state_reg <= S_IDLE;
            cur_seg_reg <= '0;
            pos_reg <= '0;
            loop_reg <= '0;
            p_base_reg <= '0;
            p_span_reg <= '0;
            p_mark_reg <= '0;
            p_loops_reg <= '0;
            o_sample <= '0;
        end else if (i_wr && i_addr == A_CTRL && i_wdata[3]) begin
            state_reg <= S_IDLE;                 // Abort
        end else begin
            case (state_reg)
                S_IDLE: if (go && i_wdata[1:0] != MODE_SCRIPT) begin
                    cur_seg_reg <= '0;
                    state_reg <= S_CHECK;
                end
                S_CHECK: begin
                    if (f_cnt > f_len || f_wfm >= wfm_cnt_reg) begin
                        ev_seg_err <= 1'b1;
                        state_reg <= S_IDLE;
                    end else begin
                        p_base_reg <= wfm_base_reg[f_wfm];
                        p_span_reg <= f_span;
                        p_mark_reg <= mode_reg == MODE_WFM ? '1 :
                            (MEM_AW+1)'(mem_reg[seq_base_reg + MEM_AW'(
                            {cur_seg_reg[SEG_IW-1:0], 2'b11})]);
                        // Loop count is split over words zero and two
                        p_loops_reg <= mode_reg == MODE_WFM ? 24'h000001 :
                            {mem_reg[seq_base_reg + MEM_AW'(
                            {cur_seg_reg[SEG_IW-1:0], 2'b00})][15:8],
                            mem_reg[seq_base_reg + MEM_AW'(
                            {cur_seg_reg[SEG_IW-1:0], 2'b10})]};
                        pos_reg <= '0;
                        loop_reg <= '0;
                        state_reg <= S_PLAY;
                    end
                end
                S_PLAY: begin
                    if (p_loops_reg == '0) begin
                        state_reg <= S_DONE;
                    end else begin
                        o_sample <= mem_reg[p_base_reg +
                            pos_reg[MEM_AW-1:0]];
                        o_sample_valid <= 1'b1;
                        o_marker <= pos_reg == p_mark_reg;
                        if (pos_reg + 1'b1 == p_span_reg) begin
                            pos_reg <= '0;
                            loop_reg <= loop_reg + 1'b1;
                            if (loop_reg + 1'b1 == p_loops_reg) begin
                                state_reg <= S_DONE;
                            end
                        end else begin
                            pos_reg <= pos_reg + 1'b1;
                        end
                    end
                end
                S_DONE: begin
                    // Next segment in list order, or finish
                    if (mode_reg == MODE_SEQ &&
                        cur_seg_reg + 1'b1 < seq_len_reg) begin
                        cur_seg_reg <= cur_seg_reg + 1'b1;
                        state_reg <= S_CHECK;
                    end else begin
                        ev_done <= 1'b1;
                        state_reg <= S_IDLE;
                    end
                end
                default: state_reg <= S_IDLE;
            endcase
        end
    end

    // ======================================================================
    // Status, mask, interrupt
    // ======================================================================
    // Set wins over a simultaneous write-one clear,
    // so an event in the clearing cycle is never lost
    always_ff @(posedge i_core_clk) begin
        if (i_reset) begin
            status_reg <= ST_RESET;
            mask_reg <= ST_RESET;
        end else begin
            status_reg <= (status_reg & ~((wr_hit && i_addr == A_STATUS) ?
                i_wdata[ST_W-1:0] : ST_RESET)) |
                {ev_full_err, ev_len_err, ev_seg_err, ev_done};
            if (wr_hit && i_addr == A_MASK) begin
                mask_reg <= i_wdata[ST_W-1:0];
            end
        end
    end

    assign o_irq = |(status_reg & mask_reg);
    // Busy decoded from the state, so an abort shows on the next cycle
    assign o_busy = state_reg != S_IDLE;

    // Read data one cycle after the strobe; unmapped reads return zero
    always_ff @(posedge i_core_clk) begin
        if (i_reset || !i_rd) begin
            o_rdata <= '0;
        end else begin
            case (i_addr)
                A_CTRL: o_rdata <= {30'h0, mode_reg};
                A_STATUS: o_rdata <= {28'h0, status_reg};
                A_MASK: o_rdata <= {28'h0, mask_reg};
                A_STATE: o_rdata <= {24'h0, 1'b0, wfm_cnt_reg,
                    cur_seg_reg[SEG_IW-1:0] == '0 ? 1'b0 : 1'b1, o_busy,
                    state_reg};
                A_FREE: o_rdata <= {21'h0, free_reg};
                default: o_rdata <= '0;
            endcase
        end
    end
endmodule : wseq_top

// File: wseq_pkg.sv
// Package: constants and types for the waveform segment sequencer
package wseq_pkg;
    // ======================================================================
    // Memory geometry
    // ======================================================================
    localparam int MEM_WORDS = 1024;            // 16-bit sample words
    localparam int MEM_AW = 10;
    localparam int BLOCK_BYTES = 128;           // Allocation granule
    localparam int BLOCK_WORDS = BLOCK_BYTES / 2;
    localparam int BLK_SHIFT = 6;               // log2 of BLOCK_WORDS
    localparam int SAMPLE_W = 16;
    localparam int NUM_WFM = 8;
    localparam int WFM_IW = 3;
    localparam int NUM_SEG = 16;
    localparam int SEG_IW = 4;
    localparam int LOOP_W = 24;
    localparam logic [LOOP_W-1:0] LOOP_MAX = 24'hFFFFFF;
    localparam int SEG_WORDS = 4;               // Instruction words per segment

    // ======================================================================
    // Register map (word index in address port)
    // ======================================================================
    localparam int ADDR_W = 8;
    localparam logic [7:0] A_CTRL = 8'h00;      // [1:0] mode,[2] go,[3] abort
    localparam logic [7:0] A_STATUS = 8'h01;    // Sticky events, W1C
    localparam logic [7:0] A_MASK = 8'h02;
    localparam logic [7:0] A_STATE = 8'h03;     // State, busy, segment nonzero, waveform count
    localparam logic [7:0] A_WFM_LEN = 8'h04;   // Allocate waveform of length
    localparam logic [7:0] A_WFM_DATA = 8'h05;  // Sample append
    localparam logic [7:0] A_SEG_CFG = 8'h06;   // [3:0] idx,[6:4] wfm
    localparam logic [7:0] A_SEG_CNT = 8'h07;   // Sample count
    localparam logic [7:0] A_SEG_LOOP = 8'h08;  // Loop count
    localparam logic [7:0] A_SEG_MARK = 8'h09;  // Marker offset, commits seg
    localparam logic [7:0] A_SEQ_LEN = 8'h0A;   // Segments in list
    localparam logic [7:0] A_RESET_MEM = 8'h0B; // New session: free all
    localparam logic [7:0] A_FREE = 8'h0C;

    // Status bits
    localparam int ST_DONE = 0;
    localparam int ST_SEG_ERR = 1;
    localparam int ST_LEN_ERR = 2;
    localparam int ST_FULL_ERR = 3;
    localparam int ST_W = 4;
    localparam logic [ST_W-1:0] ST_RESET = 4'h0;

    typedef enum logic [1:0] {
        MODE_WFM = 2'h0,
        MODE_SEQ = 2'h1,
        MODE_SCRIPT = 2'h2
    } mode_t;

    // Gray along idle -> check -> play -> done
    typedef enum logic [1:0] {
        S_IDLE = 2'h0,
        S_CHECK = 2'h1,
        S_PLAY = 2'h3,
        S_DONE = 2'h2
    } state_t;
endpackage : wseq_pkg

// File: wseq_top_asserts.sv
// Checker: port-level properties of the waveform segment sequencer
module wseq_top_asserts
    import wseq_pkg::*;
(
    input wire logic i_core_clk,
    input wire logic i_reset,
    input wire logic [ADDR_W-1:0] i_addr,
    input wire logic [31:0] i_wdata,
    input wire logic i_wr,
    input wire logic i_rd,
    input wire logic [31:0] o_rdata,
    input wire logic signed [SAMPLE_W-1:0] o_sample,
    input wire logic o_sample_valid,
    input wire logic o_marker,
    input wire logic o_busy,
    input wire logic o_irq
);
    timeunit 1ns;
    timeprecision 1ps;
    // ======================================================================
    // Properties, all in the core clock domain
    // ======================================================================
    default clocking cb @(posedge i_core_clk); endclocking
    default disable iff (i_reset);

    AST_FREE_ALIGN: assert property (
        $past(i_rd) && $past(i_addr) == A_FREE |-> o_rdata[5:0] == 6'h00)
        else $error("free pointer not on a block boundary");
    AST_SESSION_EMPTY: assert property (
        i_wr && i_addr == A_RESET_MEM ##1 !i_wr ##1 i_rd && i_addr == A_FREE
        |=> o_rdata == 32'h0) else $error("memory not empty after clear");
    AST_GO_STARTS: assert property (
        i_wr && i_addr == A_CTRL && i_wdata[3:0] == 4'h5 && !o_busy
        |-> ##[1:2] o_busy) else $error("sequence go did not start");
    AST_SCRIPT_NO_GO: assert property (
        i_wr && i_addr == A_CTRL && i_wdata[3:0] == 4'h6 && !o_busy
        |=> !o_busy [*3]) else $error("script mode started the player");
    AST_MARK_WITH_SAMPLE: assert property (
        o_marker |-> o_sample_valid) else $error("marker without sample");
    AST_SAMPLE_IN_RUN: assert property (
        o_sample_valid |-> o_busy || $past(o_busy))
        else $error("sample while idle");
    AST_STOP_STAYS: assert property (
        $fell(o_busy) && !i_wr |=> !o_busy)
        else $error("player restarted by itself");
    AST_RD_ONE_CYCLE: assert property (
        !$past(i_rd) |-> o_rdata == 32'h0) else $error("stale read data");
    AST_MASK_OFF: assert property (
        i_wr && i_addr == A_MASK && i_wdata[ST_W-1:0] == 4'h0 |=> !o_irq)
        else $error("irq high with all masked");
endmodule : wseq_top_asserts

bind wseq_top wseq_top_asserts chk (.i_core_clk(i_core_clk),
    .i_reset(i_reset), .i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr),
    .i_rd(i_rd), .o_rdata(o_rdata), .o_sample(o_sample),
    .o_sample_valid(o_sample_valid), .o_marker(o_marker), .o_busy(o_busy),
    .o_irq(o_irq));

// File: conv_sink.sv
// Model of the output conversion path fed by the sequencer
module conv_sink
    import wseq_pkg::*;
(
    input wire logic i_core_clk,
    input wire logic signed [SAMPLE_W-1:0] i_sample,
    input wire logic i_sample_valid,
    input wire logic i_marker,
    output int o_samples,
    output int o_markers,
    output logic signed [SAMPLE_W-1:0] o_last
);
    timeunit 1ns;
    timeprecision 1ps;
    // ======================================================================
    // Capture; a converter cannot stall, so every sample is taken
    // ======================================================================
    initial begin
        o_samples = 0;
        o_markers = 0;
        o_last = '0;
    end
    always @(posedge i_core_clk) begin
        if (i_sample_valid === 1'b1) begin
            o_samples <= o_samples + 1;
            o_last <= i_sample; // Whole word kept
        end
        if (i_marker === 1'b1) begin
            o_markers <= o_markers + 1;
        end
    end
endmodule : conv_sink

// File: tb_top.sv
// Testbench: bus driver, sample scoreboard and checks of the sequencer
module tb_top import wseq_pkg::*; ;
    timeunit 1ns;
    timeprecision 1ps;
    // ======================================================================
    // Stimulus signals and bookkeeping
    // ======================================================================
    logic i_core_clk = 1'b0;
    logic i_reset = 1'b1;
    logic [ADDR_W-1:0] i_addr = '0;
    logic [31:0] i_wdata = '0;
    logic i_wr = 1'b0;
    logic i_rd = 1'b0;
    logic [31:0] o_rdata;
    logic signed [SAMPLE_W-1:0] o_sample;
    logic o_sample_valid, o_marker, o_busy, o_irq;
    int fail_count = 0;
    int checks_done = 0;
    int n_smp, n_mrk;
    int lens[2];
    logic signed [SAMPLE_W-1:0] last_smp;
    logic signed [SAMPLE_W-1:0] wm[2][66];
    logic [31:0] seed = 32'hBABE166C;
    logic [31:0] v;
    logic [16:0] exp_q[$];

    always #4 i_core_clk = ~i_core_clk;

    wseq_top dut (.i_core_clk(i_core_clk), .i_reset(i_reset),
        .i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd),
        .o_rdata(o_rdata), .o_sample(o_sample),
        .o_sample_valid(o_sample_valid), .o_marker(o_marker),
        .o_busy(o_busy), .o_irq(o_irq));
    conv_sink sink (.i_core_clk(i_core_clk), .i_sample(o_sample),
        .i_sample_valid(o_sample_valid), .i_marker(o_marker),
        .o_samples(n_smp), .o_markers(n_mrk), .o_last(last_smp));

    // ======================================================================
    // Helpers
    // ======================================================================
    task automatic chk(input logic [31:0] got, exp, input string what);
        checks_done++;
        if (got !== exp) begin
            fail_count++;
            $display("ERROR %s expected %h seen %h", what, exp, got);
        end
    endtask : chk
    task automatic conclude();
        $display("checks %0d mismatches %0d", checks_done, fail_count);
        if (fail_count == 0 && checks_done > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask : conclude
    function automatic logic [31:0] xs();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction : xs
    // Idle cycle after each strobe keeps one assignment per time step
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        i_addr <= a;
        i_wdata <= d;
        i_wr <= 1'b1;
        @(posedge i_core_clk);
        i_wr <= 1'b0;
        @(posedge i_core_clk);
    endtask : wr
    task automatic rd(input logic [7:0] a);
        i_addr <= a;
        i_rd <= 1'b1;
        @(posedge i_core_clk);
        i_rd <= 1'b0;
        @(posedge i_core_clk);
        v = o_rdata;
    endtask : rd
    task automatic load(input int h, n);
        lens[h] = n;
        wr(A_WFM_LEN, 32'(n));
        for (int i = 0; i < n; i++) begin
            wm[h][i] = SAMPLE_W'(xs());
            wr(A_WFM_DATA, {16'h0000, wm[h][i]});
        end
    endtask : load
    task automatic want(input int h, n, lp, mk);
        for (int l = 0; l < lp; l++) begin
            for (int i = 0; i < n; i++) begin
                exp_q.push_back({i == mk, wm[h][i]});
            end
        end
    endtask : want
    task automatic seg(input int idx, h, cnt, lp, mk);
        int n;
        n = (cnt == 0) ? lens[h] : cnt;
        if (n <= lens[h]) begin
            want(h, n, lp, mk);
        end
        wr(A_SEG_CFG, 32'(h * 16 + idx));
        wr(A_SEG_CNT, 32'(cnt));
        wr(A_SEG_LOOP, 32'(lp));
        wr(A_SEG_MARK, 32'(mk));
    endtask : seg
    // Bounded wait; a hang counts as a mismatch and ends the run
    task automatic run(input logic [31:0] mode);
        wr(A_CTRL, mode);
        wr(A_CTRL, mode | 32'h4);
        for (int n = 0; n < 3000 && o_busy !== 1'b0; n++) begin
            @(posedge i_core_clk);
        end
        if (o_busy !== 1'b0) begin
            chk(32'h1, 32'h0, "busy timeout");
            conclude();
        end
        chk(32'(exp_q.size()), 32'h0, "samples left");
    endtask : run

    // ======================================================================
    // Scoreboard: oldest note against each sample seen
    // ======================================================================
    always @(posedge i_core_clk) begin
        if (o_sample_valid === 1'b1) begin
            if (exp_q.size() == 0) begin
                chk(32'h1, 32'h0, "extra sample");
            end else begin
                chk({o_marker, o_sample}, exp_q.pop_front(), "sample");
            end
        end
    end

    // ======================================================================
    // Main sequence
    // ======================================================================
    initial begin
        repeat (4) @(posedge i_core_clk);
        i_reset <= 1'b0;
        @(posedge i_core_clk);
        rd(A_FREE);
        chk(v, 32'h0, "free at start");
        wr(8'h20, 32'hFFFFFFFF);
        rd(8'h20);
        chk(v, 32'h0, "unmapped read");
        $display("test session start done");
        load(0, 6);
        rd(A_FREE);
        chk(v, 32'h40, "free after one");
        load(1, 66);
        rd(A_FREE);
        chk(v, 32'hC0, "free after two");
        wr(A_WFM_LEN, 32'h5);
        rd(A_STATUS);
        chk(v, 32'h4, "odd length flag");
        rd(A_FREE);
        chk(v, 32'hC0, "odd not placed");
        wr(A_STATUS, 32'hF);
        $display("test allocation done");
        wr(A_MASK, 32'h1);
        wr(A_SEQ_LEN, 32'h3);
        rd(A_FREE);
        chk(v, 32'h100, "instruction region");
        seg(0, 1, 4, 2, 1);
        seg(1, 0, 0, 1, 5);
        seg(2, 1, 66, 1, 65);
        run(32'h1);
        rd(A_STATUS);
        chk(v, 32'h1, "done flag");
        chk(32'(o_irq), 32'h1, "irq raised");
        wr(A_STATUS, 32'h1);
        chk(32'(o_irq), 32'h0, "irq cleared");
        chk(32'(n_mrk), 32'h4, "marker count");
        chk(32'(n_smp), 32'h50, "sample count");
        chk({16'h0000, last_smp}, {16'h0000, wm[1][65]}, "last word");
        $display("test sequence done");
        wr(A_SEQ_LEN, 32'h1);
        seg(0, 0, 8, 1, 0);
        run(32'h1);
        rd(A_STATUS);
        chk(v & 32'h2, 32'h2, "segment error");
        chk(32'(o_irq), 32'h0, "irq masked");
        wr(A_STATUS, 32'hF);
        $display("test segment error done");
        want(0, 6, 1, -1);
        run(32'h0);
        chk(32'(n_mrk), 32'h4, "no marker in single mode");
        // Loop count above 16 bits, cut short by an abort after 10 samples
        wr(A_SEG_CFG, 32'h0);
        wr(A_SEG_CNT, 32'h2);
        wr(A_SEG_LOOP, 32'h10000);
        wr(A_SEG_MARK, 32'hFFFFFFFF);
        want(0, 2, 5, -1);
        wr(A_CTRL, 32'h5);
        repeat (10) @(posedge i_core_clk);
        wr(A_CTRL, 32'h8);
        chk(32'(o_busy), 32'h0, "abort stops");
        chk(32'(exp_q.size()), 32'h0, "long loop samples");
        $display("test long loop done");
        wr(A_CTRL, 32'h2);
        wr(A_CTRL, 32'h6);
        chk(32'(o_busy), 32'h0, "script go ignored");
        $display("test modes done");
        wr(A_RESET_MEM, 32'h1);
        rd(A_FREE);
        chk(v, 32'h0, "free after clear");
        load(0, 4);
        rd(A_FREE);
        chk(v, 32'h40, "rewrite after clear");
        wr(A_MASK, 32'h0);
        $display("test memory clear done");
        conclude();
    end
endmodule : tb_top
